// ### hw/input_fault_and_turn_on_delay.sv
// Input overvoltage, undervoltage warning and turn-on delay control
`timescale 1ns/1ns
module input_fault_and_turn_on_delay #(
    parameter int PHASES = 2,
    parameter int TON_STEP_CYC = pwr_fault_pkg::TON_STEP_US * pwr_fault_pkg::CLK_MHZ
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic nvm_restore,
    input wire logic clear_faults,
    input wire logic enable_req,
    input wire logic ov_detect,
    input wire logic [PHASES-1:0] uv_detect,
    input wire logic pwm_tick,
    input wire logic [23:0] rise_time_cyc,
    output logic [15:0] rsp_rdata_ff,
    output logic rsp_valid_ff,
    output logic [15:0] ov_limit_word_ff,
    output logic [15:0] uv_limit_word_ff,
    output logic switching_ff,
    output logic rise_start_ff,
    output logic latched_off_ff,
    output logic status_nota_ff,
    output logic status_input_ff,
    output logic ov_flag_ff,
    output logic [PHASES-1:0] input_low_warning_flag_ff,
    output logic invalid_data_ff,
    output logic alert_n_ff
);
    import pwr_fault_pkg::*;

    // ****************************************
    // Command registers
    // ****************************************
    logic [7:0] act_ff, nxt_act;
    logic [15:0] ton_ff, nxt_ton, nxt_ov, nxt_uv, nxt_rdata;
    logic nxt_valid, bad_wr;
    logic signed [31:0] wr_q, wr_h;
    assign wr_q = lin_val(cmd_wdata, 2);
    assign wr_h = lin_val(cmd_wdata, 1);

    // Restore wins over a same-cycle write; it models the non-volatile reload
    always_comb
    begin
        nxt_ov = ov_limit_word_ff;
        nxt_uv = uv_limit_word_ff;
        nxt_ton = ton_ff;
        nxt_act = act_ff;
        bad_wr = 1'b0;
        if (nvm_restore)
        begin
            nxt_ov = {OV_EXP_RST, snap_man(lin_val(ov_limit_word_ff, 2), OV_MIN_Q, OV_MAX_Q)};
            nxt_uv = {UV_EXP_RST, snap_man(lin_val(uv_limit_word_ff, 2), UV_MIN_Q, UV_MAX_Q)};
            nxt_ton = {TON_EXP_RST, snap_man(lin_val(ton_ff, 1), 0, TON_MAX_H)};
        end
        else if (cmd_wr)
        begin
            unique case (cmd_code)
                CMD_OV_LIMIT:
                    if (wr_q < OV_MIN_Q || wr_q > OV_MAX_Q) bad_wr = 1'b1;
                    else nxt_ov = cmd_wdata;
                CMD_OV_ACTION:
                    if (cmd_wdata[ACT_MSB:ACT_LSB] == ACT_INVALID) bad_wr = 1'b1;
                    else nxt_act = cmd_wdata[7:0];
                CMD_UV_LIMIT:
                    if (wr_q < UV_MIN_Q || wr_q > UV_MAX_Q) bad_wr = 1'b1;
                    else nxt_uv = cmd_wdata;
                CMD_TURN_ON_DELAY_TIME:
                    if (wr_h < 0 || wr_h > TON_MAX_H) bad_wr = 1'b1;
                    else nxt_ton = cmd_wdata;
                default: bad_wr = 1'b1; // Unsupported command
            endcase
        end
        nxt_valid = cmd_rd;
        unique case (cmd_code)
            CMD_OV_LIMIT: nxt_rdata = ov_limit_word_ff;
            CMD_OV_ACTION: nxt_rdata = {8'h00, act_ff};
            CMD_UV_LIMIT: nxt_rdata = uv_limit_word_ff;
            CMD_TURN_ON_DELAY_TIME: nxt_rdata = ton_ff;
            default: nxt_rdata = 16'h0000;
        endcase
        if (!cmd_rd) nxt_rdata = rsp_rdata_ff;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ov_limit_word_ff <= OV_LIMIT_RST;
            uv_limit_word_ff <= UV_LIMIT_RST;
            ton_ff <= TURN_ON_DELAY_TIME_RST;
            act_ff <= OV_ACTION_RST;
            rsp_rdata_ff <= 16'h0000;
            rsp_valid_ff <= 1'b0;
        end
        else
        begin
            ov_limit_word_ff <= nxt_ov;
            uv_limit_word_ff <= nxt_uv;
            ton_ff <= nxt_ton;
            act_ff <= nxt_act;
            rsp_rdata_ff <= nxt_rdata;
            rsp_valid_ff <= nxt_valid;
        end
    end

    // ****************************************
    // Sticky status and host notify
    // ****************************************
    logic nxt_nota, nxt_input, nxt_ovf, nxt_inv;
    logic [PHASES-1:0] nxt_uvw;

    // Set beats clear so an event in the clearing cycle survives
    always_comb
    begin
        nxt_ovf = (ov_flag_ff & ~clear_faults) | ov_detect;
        nxt_uvw = (input_low_warning_flag_ff & ~{PHASES{clear_faults}}) | uv_detect;
        nxt_nota = (status_nota_ff & ~clear_faults) | ov_detect | (|uv_detect);
        nxt_input = (status_input_ff & ~clear_faults) | ov_detect | (|uv_detect);
        nxt_inv = (invalid_data_ff & ~clear_faults) | bad_wr;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ov_flag_ff <= 1'b0;
            input_low_warning_flag_ff <= '0;
            status_nota_ff <= 1'b0;
            status_input_ff <= 1'b0;
            invalid_data_ff <= 1'b0;
            alert_n_ff <= 1'b1;
        end
        else
        begin
            ov_flag_ff <= nxt_ovf;
            input_low_warning_flag_ff <= nxt_uvw;
            status_nota_ff <= nxt_nota;
            status_input_ff <= nxt_input;
            invalid_data_ff <= nxt_inv;
            alert_n_ff <= ~(nxt_ovf | (|nxt_uvw) | nxt_inv);
        end
    end

    // ****************************************
    // Start-up, fault response and retry
    // ****************************************
    state_t state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt, ton_cyc, ton_prog;
    logic [2:0] sub_ff, nxt_sub, tries_ff, nxt_tries, retry, dly, dly_clk, mult;
    logic shut, nxt_rise;
    action_t act;
    assign act = action_t'(act_ff[ACT_MSB:ACT_LSB]);
    assign retry = act_ff[RETRY_MSB:RETRY_LSB];
    assign dly = act_ff[DLY_MSB:0];
    assign dly_clk = (dly <= 3'h1) ? 3'h1 : (dly <= 3'h4) ? 3'h3 : 3'h7;
    assign mult = (dly == 3'h0) ? 3'h1 : dly;
    // Never below the self-initialisation time, even when programmed zero
    assign ton_prog = 32'(snap_man(lin_val(ton_ff, 1), 0, TON_MAX_H)) * 32'(TON_STEP_CYC);
    assign ton_cyc = (ton_prog < TON_MIN_CYC) ? 32'(TON_MIN_CYC) : ton_prog;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sub = sub_ff;
        nxt_tries = tries_ff;
        nxt_rise = 1'b0;
        shut = 1'b0;
        unique case (state_ff)
            ST_OFF:
                if (enable_req && !ov_detect)
                begin
                    nxt_state = ST_TON;
                    nxt_cnt = 32'h0;
                end
            ST_TON:
                if (cnt_ff >= ton_cyc - 32'h1)
                begin
                    if (ov_detect && act != ACT_IGNORE) shut = 1'b1;
                    else
                    begin
                        nxt_rise = 1'b1;
                        nxt_state = ST_RUN;
                        nxt_tries = 3'h0;
                    end
                end
                else nxt_cnt = cnt_ff + 32'h1;
            ST_RUN:
                if (ov_detect && act == ACT_DELAYED)
                begin
                    nxt_state = ST_OV_WAIT;
                    nxt_cnt = 32'h0;
                end
                else if (ov_detect && act == ACT_IMMEDIATE) shut = 1'b1;
            ST_OV_WAIT:
                if (!ov_detect) nxt_state = ST_RUN;
                else if (pwm_tick)
                begin
                    if (cnt_ff[2:0] == dly_clk - 3'h1) shut = 1'b1;
                    else nxt_cnt = cnt_ff + 32'h1;
                end
            ST_HICCUP:
                // One hiccup is mult rise times; a zero rise time still takes a cycle
                if (cnt_ff + 32'h1 >= 32'(rise_time_cyc))
                begin
                    nxt_cnt = 32'h0;
                    nxt_sub = sub_ff + 3'h1;
                    if (sub_ff == mult - 3'h1)
                    begin
                        nxt_state = ST_TON;
                        nxt_sub = 3'h0;
                    end
                end
                else nxt_cnt = cnt_ff + 32'h1;
            ST_LATCHED: nxt_state = ST_LATCHED;
            default: nxt_state = ST_OFF; // Unused codes fall back to off
        endcase
        if (shut)
        begin
            nxt_cnt = 32'h0;
            nxt_sub = 3'h0;
            if (retry == RETRY_FOREVER) nxt_state = ST_HICCUP;
            else if (tries_ff < retry)
            begin
                nxt_state = ST_HICCUP;
                nxt_tries = tries_ff + 3'h1;
            end
            else nxt_state = ST_LATCHED;
        end
        if (!enable_req)
        begin
            nxt_state = ST_OFF;
            nxt_cnt = 32'h0;
            nxt_sub = 3'h0;
            nxt_tries = 3'h0;
            nxt_rise = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= ST_OFF;
            cnt_ff <= 32'h0;
            sub_ff <= 3'h0;
            tries_ff <= 3'h0;
            rise_start_ff <= 1'b0;
            switching_ff <= 1'b0;
            latched_off_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sub_ff <= nxt_sub;
            tries_ff <= nxt_tries;
            rise_start_ff <= nxt_rise;
            switching_ff <= (nxt_state == ST_RUN) || (nxt_state == ST_OV_WAIT);
            latched_off_ff <= (nxt_state == ST_LATCHED);
        end
    end

    // ****************************************
    // Assertions and coverage
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_refuse_ov_start: assert property ((state_ff == ST_OFF && ov_detect) |=> state_ff != ST_TON)
        else $error("start taken with overvoltage present");
    a_ignore_keeps_run: assert property (
        (state_ff == ST_RUN && act == ACT_IGNORE && enable_req)
        |=> state_ff == ST_RUN && switching_ff)
        else $error("ignore mode left regulation");
    a_immediate_stop: assert property (
        (state_ff == ST_RUN && ov_detect && act == ACT_IMMEDIATE && enable_req)
        |=> !switching_ff)
        else $error("immediate shutdown missed");
    a_latch_no_retry: assert property (
        (shut && retry == 3'h0 && enable_req)
        |=> latched_off_ff ##1 (latched_off_ff || !enable_req))
        else $error("retry zero did not latch off");
    a_ov_status_set: assert property (
        ov_detect |=> ov_flag_ff && status_nota_ff && status_input_ff && !alert_n_ff)
        else $error("overvoltage status incomplete");
    a_uv_status_set: assert property (
        (|uv_detect)
        |=> ((input_low_warning_flag_ff & $past(uv_detect)) == $past(uv_detect))
        && status_nota_ff && status_input_ff && !alert_n_ff)
        else $error("undervoltage warning status incomplete");
    a_bad_action_kept: assert property (
        (cmd_wr && !nvm_restore && cmd_code == CMD_OV_ACTION && cmd_wdata[7:6] == 2'b11)
        |=> invalid_data_ff && $stable(act_ff))
        else $error("invalid action stored");
    a_ov_range_check: assert property (
        (cmd_wr && !nvm_restore && cmd_code == CMD_OV_LIMIT
        && (wr_q > OV_MAX_Q || wr_q < OV_MIN_Q))
        |=> invalid_data_ff && $stable(ov_limit_word_ff))
        else $error("out of range limit stored");
    a_min_turn_on: assert property (rise_start_ff |-> cnt_ff >= TON_MIN_CYC - 1)
        else $error("turn-on delay too short");
    a_retry_bound: assert property ((state_ff == ST_HICCUP && retry != RETRY_FOREVER)
        |-> tries_ff <= retry && tries_ff != 3'h0)
        else $error("hiccup beyond retry count");

    c_start_ok: cover property (state_ff == ST_TON ##1 rise_start_ff);
    c_delayed_shut: cover property (state_ff == ST_OV_WAIT ##1 latched_off_ff);
    c_latched: cover property ((state_ff == ST_TON && tries_ff != 3'h0) ##1 latched_off_ff);
endmodule

// ### hw/pwr_fault_pkg.sv
// Constants, types and linear-format helpers for the input fault block
// Behaviour
// - Input above programmed overvoltage limit declares a fault and takes selected action.
// - Limit and delay words: exponent bits 15:11, mantissa 10:0, both signed.
// - Overvoltage limit accepted 4 V to 20 V; other writes flagged invalid.
// - Power cycle or store/restore snaps overvoltage limit to nearest step.
// - Overvoltage fault sets none-of-above, input and overvoltage flags; host notified.
// - Action 00b ignores the fault and keeps regulating.
// - Action 01b keeps switching for delay cycles, then shuts down and retries.
// - Action 10b shuts down at once then retries; 11b is rejected.
// - Retry count 0 latches off after an overvoltage shutdown.
// - Retry 1 to 6: hiccup between attempts, latch off when all fail.
// - Attempts made while input stays above the limit still count.
// - Retry 7 retries forever until commanded off or start succeeds.
// - Delay field picks 1, 3 or 7 switching clocks and hiccup multiple.
// - Overvoltage present at enable blocks start-up even when ignoring.
// - Undefined action value writes are rejected and flagged invalid.
// - Undervoltage warning is detected and reported per phase.
// - Undervoltage warning sets none-of-above, input and warning flags; host notified.
// - Undervoltage warning limit accepted 2.5 V to 15.5 V only.
// - Turn-on delay spans start condition to start of output rise.
// - Turn-on delay 0 to 127.5 ms in 0.5 ms steps, snapped on restore.
// - At least about 100 us turn-on delay always, even when zero.
// - Hiccup period scales with the programmed rise time.
package pwr_fault_pkg;
    // ****************************************
    // Command codes and field layout
    // ****************************************
    localparam logic [7:0] CMD_OV_LIMIT = 8'h55;
    localparam logic [7:0] CMD_OV_ACTION = 8'h56;
    localparam logic [7:0] CMD_UV_LIMIT = 8'h58;
    localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60;
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MAN_MSB = 10;
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DLY_MSB = 2;
    // ****************************************
    // Reset values and ranges (in steps)
    // ****************************************
    localparam logic [4:0] OV_EXP_RST = 5'h1E;
    localparam logic [4:0] UV_EXP_RST = 5'h1E;
    localparam logic [4:0] TON_EXP_RST = 5'h1F;
    localparam logic [15:0] OV_LIMIT_RST = 16'hF050;
    localparam logic [15:0] UV_LIMIT_RST = 16'hF00A;
    localparam logic [15:0] TURN_ON_DELAY_TIME_RST = 16'hF800;
    localparam logic [7:0] OV_ACTION_RST = 8'h80;
    localparam int OV_MIN_Q = 16;
    localparam int OV_MAX_Q = 80;
    localparam int UV_MIN_Q = 10;
    localparam int UV_MAX_Q = 62;
    localparam int TON_MAX_H = 255;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 25;
    localparam int TON_MIN_US = 100;
    localparam int TON_STEP_US = 500;
    localparam int TON_MIN_CYC = TON_MIN_US * CLK_MHZ;
    typedef enum logic [1:0] {
        ACT_IGNORE = 2'h0, ACT_DELAYED = 2'h1, ACT_IMMEDIATE = 2'h2, ACT_INVALID = 2'h3
    } action_t;
    typedef enum logic [2:0] {
        ST_OFF, ST_TON, ST_RUN, ST_OV_WAIT, ST_HICCUP, ST_LATCHED
    } state_t;
    // Rounded value of a linear word in units of 2^-sh
    function automatic logic signed [31:0] lin_val(input logic [15:0] w, input int sh);
        int e;
        logic signed [31:0] m;
        m = 32'(signed'(w[MAN_MSB:0]));
        e = int'(signed'(w[EXP_MSB:EXP_LSB])) + sh;
        if (e > 20) e = 20;
        if (e < -20) e = -20;
        if (e >= 0) return m <<< e;
        return (m + (32'sd1 <<< (-e - 1))) >>> (-e);
    endfunction
    // Clamp a step count into the supported mantissa span
    function automatic logic [10:0] snap_man(input logic signed [31:0] v, input int lo,
                                             input int hi);
        if (v < lo) return 11'(lo);
        if (v > hi) return 11'(hi);
        return v[10:0];
    endfunction
endpackage

// ### test/input_fault_and_turn_on_delay_test.sv
// Self-checking bench for the input fault and turn-on delay block
`timescale 1ns/1ns
module input_fault_and_turn_on_delay_test;
    import pwr_fault_pkg::*;
    // ****************************************
    // Signals and tables
    // ****************************************
    logic clk, rstn, cmd_wr, cmd_rd, nvm_restore, clear_faults, enable_req, ov_detect, pwm_tick;
    logic rsp_valid_ff, switching_ff, rise_start_ff, latched_off_ff, status_nota_ff;
    logic status_input_ff, ov_flag_ff, invalid_data_ff, alert_n_ff;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata_ff, ov_limit_word_ff, uv_limit_word_ff, rd;
    logic [1:0] uv_detect, input_low_warning_flag_ff;
    logic [23:0] rise_time_cyc;
    logic [2:0] tick_cnt;
    logic [15:0] shadow [logic [7:0]];
    int failures, checks, n;
    bit ok, hit;
    // Write table: code, data, refused mask (bit per row)
    logic [7:0] wc [12] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h56, 8'h56, 8'h58, 8'h58, 8'h58,
                            8'h60, 8'h60, 8'h57};
    logic [15:0] wd [12] = '{16'hF010, 16'hF00F, 16'hF051, 16'hF050, 16'h00C0, 16'h0042,
                             16'hF03E, 16'hF03F, 16'hF009, 16'hF8FF, 16'hF900, 16'h1234};
    logic [11:0] bad = 12'hD96;

    input_fault_and_turn_on_delay #(.PHASES(2), .TON_STEP_CYC(10)) dut (
        .clk, .rstn, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .nvm_restore, .clear_faults,
        .enable_req, .ov_detect, .uv_detect, .pwm_tick, .rise_time_cyc, .rsp_rdata_ff,
        .rsp_valid_ff, .ov_limit_word_ff, .uv_limit_word_ff, .switching_ff, .rise_start_ff,
        .latched_off_ff, .status_nota_ff, .status_input_ff, .ov_flag_ff,
        .input_low_warning_flag_ff, .invalid_data_ff, .alert_n_ff);
    pmbus_host_model host (.clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .rsp_rdata_ff,
        .rsp_valid_ff);

    // ****************************************
    // Clock, switching tick and helpers
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // One switching tick every eight system clocks
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            tick_cnt <= 3'h0;
            pwm_tick <= 1'b0;
        end
        else
        begin
            tick_cnt <= tick_cnt + 3'h1;
            pwm_tick <= (tick_cnt == 3'h7);
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Flags packed: none-of-above, input, overvoltage, phase warnings, alert
    function automatic logic [15:0] flags();
        return {10'h0, status_nota_ff, status_input_ff, ov_flag_ff, input_low_warning_flag_ff,
                alert_n_ff};
    endfunction
    // Bounded wait: 0 rise start, 1 switching stopped, 2 latched off
    task automatic wait_for(input int sel, input int lim, output int cnt, output bit got);
        cnt = 0;
        got = 1'b0;
        while (!got && cnt < lim)
        begin
            @(posedge clk);
            cnt++;
            got = (sel == 0) ? (rise_start_ff === 1'b1) : (sel == 1) ? (switching_ff === 1'b0)
                : (latched_off_ff === 1'b1);
        end
    endtask
    task automatic wait_must(input int sel, input int lim);
        wait_for(sel, lim, n, hit);
        if (!hit)
        begin
            failures++;
            $display("[ERR] %0t wait ran out", $time);
            end_sim();
        end
    endtask
    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
        host.read_word(code, rd, ok);
        check({15'h0, ok}, 16'h0001);
        check(rd, exp);
    endtask
    // Back to off; clear held two edges so a late flag set cannot survive
    task automatic idle();
        @(posedge clk);
        enable_req <= 1'b0;
        ov_detect <= 1'b0;
        clear_faults <= 1'b1;
        repeat (2) @(posedge clk);
        clear_faults <= 1'b0;
        @(posedge clk);
    endtask
    // Start with a window of a few cycles for the registered pulse
    task automatic start(input int lo);
        @(posedge clk);
        enable_req <= 1'b1;
        wait_must(0, 3000);
        check({15'h0, n >= lo && n <= lo + 3}, 16'h0001);
    endtask
    task automatic fault_on(input logic [15:0] act);
        host.write_word(CMD_OV_ACTION, act);
        start(2500);
        ov_detect <= 1'b1;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rstn = 1'b0;
        {nvm_restore, clear_faults, enable_req, ov_detect} = 4'h0;
        uv_detect = 2'h0;
        rise_time_cyc = 24'd20;
        failures = 0;
        checks = 0;
        shadow[8'h55] = 16'hF050;
        shadow[8'h56] = 16'h0080;
        shadow[8'h58] = 16'hF00A;
        shadow[8'h60] = 16'hF800;
        shadow[8'h57] = 16'h0000;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        foreach (shadow[c]) rd_chk(c, shadow[c]);
        check(flags(), 16'h0001);
        for (int i = 0; i < 12; i++)
        begin
            host.write_word(wc[i], wd[i]);
            check({15'h0, invalid_data_ff}, {15'h0, bad[i]});
            check({15'h0, alert_n_ff}, {15'h0, !bad[i]});
            if (!bad[i])
                shadow[wc[i]] = (wc[i] == CMD_OV_ACTION) ? {8'h00, wd[i][7:0]} : wd[i];
            rd_chk(wc[i], shadow[wc[i]]);
            idle();
        end
        // Words in another exponent snap to the stored step on restore
        host.write_word(CMD_OV_LIMIT, 16'h0005);
        host.write_word(CMD_TURN_ON_DELAY_TIME, 16'h0001);
        host.write_word(CMD_UV_LIMIT, 16'h0003);
        @(posedge clk);
        nvm_restore <= 1'b1;
        @(posedge clk);
        nvm_restore <= 1'b0;
        @(posedge clk);
        check(ov_limit_word_ff, 16'hF014);
        check(uv_limit_word_ff, 16'hF00C);
        rd_chk(CMD_TURN_ON_DELAY_TIME, 16'hF802);
        host.write_word(CMD_TURN_ON_DELAY_TIME, 16'hF800);
        start(2500);
        idle();
        host.write_word(CMD_TURN_ON_DELAY_TIME, 16'hF8FF);
        start(2550);
        idle();
        host.write_word(CMD_TURN_ON_DELAY_TIME, 16'hF800);
        // Ignore mode still refuses a start into a present fault
        host.write_word(CMD_OV_ACTION, 16'h0000);
        ov_detect <= 1'b1;
        @(posedge clk);
        enable_req <= 1'b1;
        wait_for(0, 3000, n, hit);
        check({15'h0, hit}, 16'h0000);
        idle();
        fault_on(16'h0000);
        wait_for(1, 200, n, hit);
        check({15'h0, hit}, 16'h0000);
        check(flags(), 16'h0038);
        idle();
        fault_on(16'h0080);
        wait_for(1, 3, n, hit);
        check({15'h0, hit}, 16'h0001);
        wait_must(2, 4);
        idle();
        fault_on(16'h0042);
        wait_for(1, 10, n, hit);
        check({15'h0, hit}, 16'h0000);
        wait_must(1, 30);
        wait_must(2, 4);
        idle();
        // Two unseen attempts, each a hiccup of three rise times then a full wait
        fault_on(16'h0093);
        wait_for(2, 5100, n, hit);
        check({15'h0, hit}, 16'h0000);
        wait_must(2, 40);
        idle();
        fault_on(16'h00B8);
        wait_for(2, 8000, n, hit);
        check({15'h0, hit}, 16'h0000);
        ov_detect <= 1'b0;
        wait_must(0, 2700);
        idle();
        uv_detect <= 2'b10;
        repeat (3) @(posedge clk);
        check(flags(), 16'h0034);
        uv_detect <= 2'b00;
        end_sim();
    end
endmodule

// ### test/pmbus_host_model.sv
// Host model that issues command reads and writes to the fault block
`timescale 1ns/1ns
module pmbus_host_model (
    input wire logic clk,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] rsp_rdata_ff,
    input wire logic rsp_valid_ff
);
    // Idle bus at time zero
    initial
    begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // One whole word per request, held only for the taking edge
    task automatic write_word(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk);
        cmd_wr <= 1'b1;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge clk);
        cmd_wr <= 1'b0;
        cmd_code <= ~code; // Released lines never show stale values
        cmd_wdata <= ~data;
        @(posedge clk);
    endtask

    // Answer is expected one cycle after the taking edge; bounded wait
    task automatic read_word(input logic [7:0] code, output logic [15:0] data, output bit ok);
        int n;
        ok = 1'b0;
        data = 16'h0000;
        @(posedge clk);
        cmd_rd <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_rd <= 1'b0;
        cmd_code <= ~code;
        for (n = 0; n < 4 && !ok; n++)
        begin
            @(posedge clk);
            if (rsp_valid_ff === 1'b1)
            begin
                ok = 1'b1;
                data = rsp_rdata_ff;
            end
        end
    endtask
endmodule
